// file: pkg/dmpd_params.svh
// Constants of the dual-modulus divider: presets, terminal values, moduli.
// Assumes inclusion by bare name from package and design files.
`ifndef DMPD_PARAMS_SVH
`define DMPD_PARAMS_SVH

// ----------------------------------------------------------------------
// Loop figures
// ----------------------------------------------------------------------
`define DMPD_REF_RATE_KHZ      40
`define DMPD_RATIO_MIN         4291
`define DMPD_RATIO_MAX         7290
`define DMPD_TERM_COUNT        3709

// ----------------------------------------------------------------------
// Preset offsets and BCD limits
// ----------------------------------------------------------------------
`define DMPD_TOP_ADD           4'h8
`define DMPD_BCD_MAX           4'h9
`define DMPD_BCD_ZERO          4'h0

// ----------------------------------------------------------------------
// Prescaler stages
// ----------------------------------------------------------------------
`define DMPD_TEN_LAST          4'h9
`define DMPD_ELEVEN_LAST       4'hA
`define DMPD_FIVE_LAST         3'h4

// ----------------------------------------------------------------------
// Swallow terminal 09, wrap value 49
// ----------------------------------------------------------------------
`define DMPD_SW_TERM_TENS      3'h0
`define DMPD_SW_TERM_UNITS     4'h9
`define DMPD_SW_WRAP_TENS      3'h4

// ----------------------------------------------------------------------
// Programmable counter early-decode value 380 / 381
// ----------------------------------------------------------------------
`define DMPD_PC_EARLY_TOP      4'h3
`define DMPD_PC_EARLY_MID      4'h8

`endif

// file: pkg/dmpd_pkg.sv
// Types used by the divider; the prescaler imports the package but uses none of them.
// Assumes dmpd_params.svh is on the include path.
`include "dmpd_params.svh"

package dmpd_pkg;

  // Early-decode sequencer, one-hot
  typedef enum logic [2:0] {
    DMPD_ED_INIT = 3'b001,
    DMPD_ED_RUN  = 3'b010,
    DMPD_ED_LOW  = 3'b100
  } dmpd_ed_state_t;

  // Swallow counter: mod-5 tens, decade units
  typedef struct packed {
    logic [2:0] tens;
    logic [3:0] units;
  } dmpd_swallow_t;

  // Programmable counter: top decade, middle decade, halves bit
  typedef struct packed {
    logic [3:0] top;
    logic [3:0] mid;
    logic       half;
  } dmpd_prog_t;

endpackage : dmpd_pkg

// file: pkg/dmpd_presc_if.sv
// Link between the counter chain and the 50/51 prescaler.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ns

interface dmpd_presc_if;
  logic ce;
  logic vco_pulse;
  logic modulus_select_input;
  logic presc_pulse;
  logic eleven_count_enable_n;

  modport presc (
    input  ce,
    input  vco_pulse,
    input  modulus_select_input,
    output presc_pulse,
    output eleven_count_enable_n
  );

  modport ctrl (
    output ce,
    output vco_pulse,
    output modulus_select_input,
    input  presc_pulse,
    input  eleven_count_enable_n
  );
endinterface : dmpd_presc_if

// file: design/dmpd_prescaler.sv
// Dual-modulus 50/51 prescaler: divide-by-10/11 stage and divide-by-5 stage.
// Assumes vco_pulse is a one-clock strobe per oscillator input pulse.
`timescale 1ns/1ns
`include "dmpd_params.svh"

module dmpd_prescaler
  import dmpd_pkg::*;
(
  // Clock and reset
  input wire logic    mclk_i,
  input wire logic    rst_b_i,
  // Counter-chain side
  dmpd_presc_if.presc pif
);

  logic [3:0] ten_reg;
  logic [2:0] five_reg;
  logic       pulse_reg;

  wire        eleven_sel_n;
  wire  [3:0] ten_last;
  wire        ten_wrap;
  wire        five_wrap;

  // ----------------------------------------------------------------------
  // Modulus decode
  // ----------------------------------------------------------------------
  // once in five
  assign eleven_sel_n = (five_reg != `DMPD_FIVE_LAST);
  assign ten_last  = (!pif.modulus_select_input && !eleven_sel_n) ? `DMPD_ELEVEN_LAST : `DMPD_TEN_LAST;
  assign ten_wrap  = pif.vco_pulse && (ten_reg == ten_last);
  assign five_wrap = ten_wrap && (five_reg == `DMPD_FIVE_LAST);

  assign pif.eleven_count_enable_n = eleven_sel_n;
  assign pif.presc_pulse           = pulse_reg;

  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  // 50 or 51 per cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ten_reg   <= 4'h0;
      five_reg  <= 3'h0;
      pulse_reg <= 1'b0;
    end else if (pif.ce) begin
      if (pif.vco_pulse) begin
        ten_reg <= ten_wrap ? 4'h0 : ten_reg + 4'h1;
      end
      if (ten_wrap) begin
        five_reg <= five_wrap ? 3'h0 : five_reg + 3'h1;
      end
      pulse_reg <= five_wrap;
    end
  end

endmodule : dmpd_prescaler

// file: design/dmpd_divider.sv
// Programmable divide-by-N chain for the first local-oscillator loop.
// Assumes vco_pulse_i is a synchronous one-clock strobe per oscillator
// pulse and the tuning word is stable BCD in 0000..2999.
`timescale 1ns/1ns
`include "dmpd_params.svh"

module dmpd_divider
  import dmpd_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // Oscillator input strobe
  input  wire logic        vco_pulse_i,
  // Tuning word, four BCD digits
  input  wire logic [15:0] tune_bcd_i,
  // Phase-detector side
  output logic             early_decode_n_o,
  output logic             phase_det_pulse_o,
  // Chain status
  output logic             prescaler_pulse_o,
  output logic             zero_detect_o,
  output logic             carry_flag_o,
  // Oscillator band select
  output logic [2:0]       band_code_o
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------

  // One BCD digit down, 0 wraps to 9
  function automatic logic [3:0] bcd_down(input logic [3:0] d);
    bcd_down = (d == `DMPD_BCD_ZERO) ? `DMPD_BCD_MAX : d - 4'h1;
  endfunction : bcd_down

  // BCD to biquinary {five, quinary}; a constant table
  function automatic logic [3:0] biquinary_code_rom(input logic [3:0] d);
    case (d)
      4'h0:    biquinary_code_rom = 4'h0;
      4'h1:    biquinary_code_rom = 4'h1;
      4'h2:    biquinary_code_rom = 4'h2;
      4'h3:    biquinary_code_rom = 4'h3;
      4'h4:    biquinary_code_rom = 4'h4;
      4'h5:    biquinary_code_rom = 4'h8;
      4'h6:    biquinary_code_rom = 4'h9;
      4'h7:    biquinary_code_rom = 4'hA;
      4'h8:    biquinary_code_rom = 4'hB;
      4'h9:    biquinary_code_rom = 4'hC;
      default: biquinary_code_rom = 4'h0;
    endcase
  endfunction : biquinary_code_rom

  // Swallow step: units down, tens down mod 5
  function automatic dmpd_swallow_t swallow_down(input dmpd_swallow_t s);
    dmpd_swallow_t r;
    r       = s;
    r.units = bcd_down(s.units);
    if (s.units == `DMPD_BCD_ZERO) begin
      r.tens = (s.tens == 3'h0) ? `DMPD_SW_WRAP_TENS : s.tens - 3'h1;
    end
    swallow_down = r;
  endfunction : swallow_down

  // Programmable step: halves, then middle, then top
  function automatic dmpd_prog_t prog_down(input dmpd_prog_t p);
    dmpd_prog_t r;
    r      = p;
    r.half = ~p.half;
    if (!p.half) begin
      r.mid = bcd_down(p.mid);
      if (p.mid == `DMPD_BCD_ZERO) begin
        r.top = p.top - 4'h1;
      end
    end
    prog_down = r;
  endfunction : prog_down

  // Tuned MHz (0..29) in steps of four MHz of oscillator band
  function automatic logic [2:0] band_code_encoder(input logic [3:0] tens, input logic [3:0] units);
    logic [6:0] mhz;
    mhz = 7'(tens) * 7'h0A + 7'(units);
    band_code_encoder = mhz[4:2];
  endfunction : band_code_encoder

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  dmpd_presc_if   presc_bus ();

  dmpd_ed_state_t ed_state_reg;
  dmpd_swallow_t  swallow_reg;
  dmpd_prog_t     prog_reg;
  logic           valid_reg;
  logic           carry_reg;
  logic           zero_det_reg;
  logic           pd_pulse_reg;
  logic [2:0]     band_reg;

  wire [3:0]      dig_thou;
  wire [3:0]      dig_hund;
  wire [3:0]      dig_tens;
  wire [3:0]      dig_units;
  wire [3:0]      top_preset;
  wire [3:0]      bq_code;
  dmpd_swallow_t  swallow_preset;
  dmpd_prog_t     prog_preset;
  wire            preset_no_carry;

  wire            adv;
  wire            load_now;
  wire            init_now;
  wire            swallow_at_term;
  wire            swallow_hit;
  wire            swallow_wrap;
  wire            modulus_fifty;
  dmpd_prog_t     early_value;
  wire            early_hit;

  // ----------------------------------------------------------------------
  // Preset decode
  // ----------------------------------------------------------------------
  // BCD tuning digits
  assign dig_thou  = tune_bcd_i[15:12];
  assign dig_hund  = tune_bcd_i[11:8];
  assign dig_tens  = tune_bcd_i[7:4];
  assign dig_units = tune_bcd_i[3:0];

  assign top_preset = dig_thou + `DMPD_TOP_ADD;

  assign bq_code = biquinary_code_rom(dig_tens);

  // Halves bit joins the programmable count, quinary part the swallow count
  assign swallow_preset.tens  = bq_code[2:0];
  assign swallow_preset.units = dig_units;
  assign prog_preset.top      = top_preset;
  assign prog_preset.mid      = dig_hund;
  assign prog_preset.half     = bq_code[3];

  assign preset_no_carry = (swallow_preset.tens != 3'h0) || (swallow_preset.units == `DMPD_SW_TERM_UNITS);

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  assign presc_bus.ce                   = ce_i;
  assign presc_bus.vco_pulse            = vco_pulse_i;
  assign presc_bus.modulus_select_input = modulus_fifty;

  dmpd_prescaler u_prescaler (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .pif     (presc_bus.presc)
  );

  // ----------------------------------------------------------------------
  // Count decode
  // ----------------------------------------------------------------------
  // one shared advance
  assign adv      = ce_i && presc_bus.presc_pulse;
  assign init_now = ce_i && (ed_state_reg == DMPD_ED_INIT);
  assign load_now = adv && (ed_state_reg == DMPD_ED_LOW);

  assign swallow_at_term = (swallow_reg.tens == `DMPD_SW_TERM_TENS) && (swallow_reg.units == `DMPD_SW_TERM_UNITS);
  assign swallow_hit     = valid_reg && swallow_at_term;
  assign swallow_wrap    = (swallow_reg.tens == 3'h0) && (swallow_reg.units == `DMPD_BCD_ZERO);

  assign modulus_fifty = zero_det_reg || swallow_hit;

  assign early_value.top  = `DMPD_PC_EARLY_TOP;
  assign early_value.mid  = `DMPD_PC_EARLY_MID;
  assign early_value.half = carry_reg;

  assign early_hit = (ed_state_reg == DMPD_ED_RUN) && (prog_reg == early_value);

  // ----------------------------------------------------------------------
  // Early-decode sequencer
  // ----------------------------------------------------------------------
  // Reset waits in INIT so the presets load from live inputs, not constants
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ed_state_reg <= DMPD_ED_INIT;
    end else begin
      case (ed_state_reg)
        DMPD_ED_INIT: begin
          if (ce_i) begin
            ed_state_reg <= DMPD_ED_RUN;
          end
        end
        DMPD_ED_RUN: begin
          if (adv && early_hit) begin
            ed_state_reg <= DMPD_ED_LOW;
          end
        end
        DMPD_ED_LOW: begin
          if (adv) begin
            ed_state_reg <= DMPD_ED_RUN;
          end
        end
        default: begin
          ed_state_reg <= DMPD_ED_INIT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Programmable counter
  // ----------------------------------------------------------------------
  // count down to terminal
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prog_reg <= '0;
    end else if (init_now || load_now) begin
      prog_reg <= prog_preset;
    end else if (adv) begin
      prog_reg <= prog_down(prog_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Swallow counter, validation and carry
  // ----------------------------------------------------------------------
  // swallow frozen after terminal
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      swallow_reg <= '0;
    end else if (init_now || load_now) begin
      swallow_reg <= swallow_preset;
    end else if (adv && !modulus_fifty) begin
      swallow_reg <= swallow_down(swallow_reg);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      valid_reg <= 1'b0;
    end else if (init_now || load_now) begin
      valid_reg <= preset_no_carry;
    end else if (adv && !modulus_fifty && swallow_wrap) begin
      valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      carry_reg <= 1'b0;
    end else if (init_now || load_now) begin
      carry_reg <= 1'b0;
    end else if (adv && !modulus_fifty && swallow_wrap) begin
      carry_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Zero detector
  // ----------------------------------------------------------------------
  // set at swallow terminal
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      zero_det_reg <= 1'b0;
    end else if (init_now || load_now) begin
      zero_det_reg <= 1'b0;
    end else if (ce_i && swallow_hit) begin
      zero_det_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Phase-detector pulse and band code
  // ----------------------------------------------------------------------
  // one pulse per cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pd_pulse_reg <= 1'b0;
    end else if (ce_i) begin
      pd_pulse_reg <= load_now;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      band_reg <= 3'h0;
    end else if (ce_i) begin
      band_reg <= band_code_encoder(dig_thou, dig_hund);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // ratio is preset minus terminal
  // Low exactly while the sequencer sits in its load state
  assign early_decode_n_o  = (ed_state_reg != DMPD_ED_LOW);
  assign phase_det_pulse_o = pd_pulse_reg;
  assign prescaler_pulse_o = presc_bus.presc_pulse;
  assign zero_detect_o     = zero_det_reg;
  assign carry_flag_o      = carry_reg;
  assign band_code_o       = band_reg;

endmodule : dmpd_divider

// file: verif/dmpd_divider_chk.sv
// Port-level assertions for the divide-by-N chain.
// Assumes a bind from the bench top file; one clock domain.
`timescale 1ns/1ns

module dmpd_divider_chk (
  // Clock, reset and inputs
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  input wire logic        vco_pulse_i,
  input wire logic [15:0] tune_bcd_i,
  // Watched outputs
  input wire logic        early_decode_n_o,
  input wire logic        phase_det_pulse_o,
  input wire logic        prescaler_pulse_o,
  input wire logic        zero_detect_o,
  input wire logic        carry_flag_o,
  input wire logic [2:0]  band_code_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // Input strobes since the last prescaler pulse
  // ----------------------------------------------------------------
  logic [6:0] vco_cnt_reg;
  logic [6:0] vco_cnt_next;
  logic [5:0] mhz;
  logic [2:0] band_exp;

  assign vco_cnt_next = (prescaler_pulse_o ? 7'h0 : vco_cnt_reg) + 7'(vco_pulse_i);
  assign mhz          = 6'(tune_bcd_i[15:12]) * 6'hA + 6'(tune_bcd_i[11:8]);
  assign band_exp     = mhz[4:2];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      vco_cnt_reg <= 7'h0;
    else if (ce_i)
      vco_cnt_reg <= vco_cnt_next;
  end

  sequence s_period_end;
    ce_i && prescaler_pulse_o;
  endsequence

  sequence s_reload;
    ce_i && prescaler_pulse_o && !early_decode_n_o;
  endsequence

  chk_presc_len: assert property (s_period_end |-> vco_cnt_reg == 7'h32 || vco_cnt_reg == 7'h33)
    else $error("prescaler period is not 50 or 51 strobes");
  chk_zd_fifty: assert property (s_period_end and zero_detect_o && $past(zero_detect_o) |-> vco_cnt_reg == 7'h32)
    else $error("period after swallow end is not 50 strobes");
  chk_ed_cause: assert property ($fell(early_decode_n_o) |-> $past(prescaler_pulse_o))
    else $error("early decode fell without a prescaler pulse");
  chk_ed_hold: assert property (!early_decode_n_o && !(ce_i && prescaler_pulse_o) |=> !early_decode_n_o)
    else $error("early decode rose before the next prescaler pulse");
  chk_reload_rise: assert property (s_reload |=> early_decode_n_o)
    else $error("early decode stayed low after reload pulse");
  chk_pd_follow: assert property ($rose(early_decode_n_o) |-> ##[0:2] phase_det_pulse_o)
    else $error("no phase pulse after early decode rose");
  chk_pd_cause: assert property ($rose(phase_det_pulse_o)
    |-> !$past(early_decode_n_o, 1) || !$past(early_decode_n_o, 2) || !$past(early_decode_n_o, 3))
    else $error("phase pulse without a reload");
  chk_pd_single: assert property (phase_det_pulse_o && ce_i |=> !phase_det_pulse_o)
    else $error("phase pulse longer than one cycle");
  chk_zd_clear: assert property ($fell(zero_detect_o)
    |-> !$past(early_decode_n_o, 1) || !$past(early_decode_n_o, 2) || !$past(early_decode_n_o, 3))
    else $error("zero detector cleared outside reload");
  chk_carry_early: assert property ($rose(carry_flag_o) |-> !zero_detect_o)
    else $error("carry set after swallow end");
  chk_band_code: assert property (ce_i |=> band_code_o == $past(band_exp))
    else $error("band code does not follow tuning digits");
endmodule : dmpd_divider_chk

// file: verif/dmpd_pll_model.sv
// Oscillator and phase-detector stand-in for the divider.
// Assumes the bench drives ce_i and gap_i; one clock.
`timescale 1ns/1ns

module dmpd_pll_model (
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // Oscillator spacing: one strobe every gap_i+1 cycles
  input  wire logic [1:0]  gap_i,
  // Divider outputs
  input  wire logic        phase_det_pulse_i,
  input  wire logic        prescaler_pulse_i,
  // Oscillator strobe and measured cycle
  output logic             vco_pulse_o,
  output logic [15:0]      ratio_o,
  output logic [7:0]       long_cnt_o
);
  logic [1:0]  gap_reg;
  logic [15:0] acc_reg;
  logic [6:0]  per_reg;
  logic [7:0]  long_reg;
  logic        take;
  logic        long_hit;

  assign take     = ce_i && vco_pulse_o;
  assign long_hit = ce_i && prescaler_pulse_i && per_reg == 7'h33;

  // Oscillator keeps running while the divider is frozen
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_reg     <= 2'h0;
      vco_pulse_o <= 1'b0;
    end else begin
      gap_reg     <= (gap_reg >= gap_i) ? 2'h0 : gap_reg + 2'h1;
      vco_pulse_o <= (gap_reg >= gap_i);
    end
  end

  // ----------------------------------------------------------------
  // Phase detector side: strobes and 51-periods per cycle
  // ----------------------------------------------------------------
  // one cycle between pulses
  // Cycle total is summed from whole prescaler periods: the phase pulse lags the
  // last counted strobe by two enabled edges, so a raw strobe count would slip
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_reg    <= 16'h0;
      per_reg    <= 7'h0;
      long_reg   <= 8'h0;
      ratio_o    <= 16'h0;
      long_cnt_o <= 8'h0;
    end else if (ce_i) begin
      acc_reg  <= (phase_det_pulse_i ? 16'h0 : acc_reg) + (prescaler_pulse_i ? 16'(per_reg) : 16'h0);
      per_reg  <= (prescaler_pulse_i ? 7'h0 : per_reg) + 7'(take);
      long_reg <= (phase_det_pulse_i ? 8'h0 : long_reg) + 8'(long_hit);
      if (phase_det_pulse_i) begin
        ratio_o    <= acc_reg;
        long_cnt_o <= long_reg;
      end
    end
  end
endmodule : dmpd_pll_model

// file: verif/tb_top.sv
// Bench for the divider: tuning table, gated slow input, mid-run reset.
// Assumes the partner model supplies oscillator strobes and measures cycles.
`timescale 1ns/1ns
`include "dmpd_params.svh"

module tb_top;
  logic        mclk;
  logic        rst_b;
  logic        ce;
  logic        vco;
  logic [15:0] tune;
  logic [1:0]  gap;
  logic        ce_pat;
  logic        ed_n;
  logic        pd;
  logic        pp;
  logic        zd;
  logic        cf;
  logic [2:0]  band;
  logic [15:0] ratio;
  logic [7:0]  long_cnt;
  logic        carry_seen;
  logic        carry_last;
  int          cyc;
  int          err_count;
  int          tests_run;

  dmpd_divider dmpd_divider_i (
    .mclk_i(mclk), .rst_b_i(rst_b), .ce_i(ce), .vco_pulse_i(vco), .tune_bcd_i(tune),
    .early_decode_n_o(ed_n), .phase_det_pulse_o(pd), .prescaler_pulse_o(pp),
    .zero_detect_o(zd), .carry_flag_o(cf), .band_code_o(band)
  );

  dmpd_pll_model dmpd_pll_model_i (
    .mclk_i(mclk), .rst_b_i(rst_b), .ce_i(ce), .gap_i(gap), .phase_det_pulse_i(pd),
    .prescaler_pulse_i(pp), .vco_pulse_o(vco), .ratio_o(ratio), .long_cnt_o(long_cnt)
  );

  always #50 mclk = ~mclk;

  // Gated enable drops every third cycle; carry remembered per cycle
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    ce  <= !(ce_pat && (cyc % 3 == 0));
    if (pd === 1'b1 && ce === 1'b1) begin
      carry_last <= carry_seen | (cf === 1'b1);
      carry_seen <= 1'b0;
    end else if (cf === 1'b1) begin
      carry_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp

  task automatic wait_phase;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(pd === 1'b1 && ce === 1'b1) && n < 20000);
    if (n >= 20000) begin
      err_count++;
      $display("MISMATCH %0t no phase pulse", $time);
      close_out();
    end
  endtask : wait_phase

  // New presets take effect at the next reload; the first full cycle on them is judged
  task automatic check_cycle(input logic [15:0] tv);
    int dec;
    int sw;
    dec = tv[15:12] * 1000 + tv[11:8] * 100 + tv[7:4] * 10 + tv[3:0];
    sw  = (tv[7:4] % 5) * 10 + tv[3:0];
    @(posedge mclk);
    tune <= tv;
    wait_phase();
    wait_phase();
    #1;
    cmp(ratio, 16'(`DMPD_TOP_ADD * 1000 + dec - `DMPD_TERM_COUNT));
    cmp(16'(long_cnt), 16'((sw + 41) % 50));
    cmp(16'(carry_last), 16'(sw < 9));
    cmp(16'(band), 16'((tv[15:12] * 10 + tv[11:8]) / 4));
  endtask : check_cycle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_table;
    logic [15:0] tbl [4];
    tbl = '{16'h0000, 16'h2999, 16'h0009, 16'h1357};
    foreach (tbl[i]) check_cycle(tbl[i]);
  endtask : t_table

  task automatic t_slow;
    @(posedge mclk);
    gap    <= 2'h1;
    ce_pat <= 1'b1;
    check_cycle(16'h0008);
    @(posedge mclk);
    gap    <= 2'h0;
    ce_pat <= 1'b0;
  endtask : t_slow

  task automatic t_reset;
    repeat (300) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    cmp({8'h0, ed_n, pd, pp, zd, cf, band}, 16'h0080);
    @(posedge mclk);
    rst_b <= 1'b1;
    check_cycle(16'h0550);
  endtask : t_reset

  initial begin
    mclk       = 1'b0;
    rst_b      = 1'b0;
    ce         = 1'b1;
    tune       = 16'h0000;
    gap        = 2'h0;
    ce_pat     = 1'b0;
    carry_seen = 1'b0;
    carry_last = 1'b0;
    cyc        = 0;
    err_count  = 0;
    tests_run  = 0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_table();
    t_slow();
    t_reset();
    close_out();
  end
endmodule : tb_top

bind dmpd_divider dmpd_divider_chk dmpd_divider_chk_i (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .vco_pulse_i(vco_pulse_i), .tune_bcd_i(tune_bcd_i),
  .early_decode_n_o(early_decode_n_o), .phase_det_pulse_o(phase_det_pulse_o),
  .prescaler_pulse_o(prescaler_pulse_o), .zero_detect_o(zero_detect_o),
  .carry_flag_o(carry_flag_o), .band_code_o(band_code_o)
);
